// *** hw/mrs_pkg.sv ***
// Purpose: shared constants and types of the multi-reference step sequencer
// Assumes: 32-bit Avalon-MM slave with word addressing by byte offset
// Notes:   set points in units of 0.1 %, run times in units of 0.1 s or 0.1 h
package mrs_pkg;
  localparam int          NUM_STEPS    = 16;
  localparam int          IDX_W        = 4;
  localparam int          ADDR_W       = 8;
  // register byte offsets
  localparam logic [7:0]  OFS_SETPOINT = 8'h00;  // 16 words
  localparam logic [7:0]  OFS_RUNTIME  = 8'h40;  // 16 words
  localparam logic [7:0]  OFS_RAMP     = 8'h80;  // 16 words
  localparam logic [7:0]  OFS_CONFIG   = 8'hC0;
  localparam logic [7:0]  OFS_RETAIN   = 8'hC4;
  localparam logic [7:0]  OFS_COMMAND  = 8'hC8;
  localparam logic [7:0]  OFS_STATUS   = 8'hCC;
  localparam logic [7:0]  OFS_SAVED    = 8'hD0;
  localparam logic [7:0]  OFS_TOP      = 8'hD4;
  // field positions
  localparam int          CFG_SEQ_BIT  = 0;
  localparam int          CFG_END_LSB  = 1;
  localparam int          CFG_UNIT_BIT = 3;
  localparam int          CFG_SRC_LSB  = 4;
  localparam int          CMD_RUN_BIT  = 0;
  localparam int          CMD_STOP_BIT = 1;
  localparam int          CMD_PDN_BIT  = 2;
  // value limits and reset values
  localparam logic signed [15:0] SP_MAX    = 16'sh03E8;  // 100.0 %
  localparam logic signed [15:0] SP_MIN    = -16'sh03E8; // -100.0 %
  localparam logic signed [15:0] SP_RESET  = 16'sh0000;
  localparam logic [15:0]        TIME_RESET = 16'h0000;
  localparam logic [1:0]         RAMP_RESET = 2'h0;
  localparam logic [25:0]        PCT_FULL   = 26'h00003E8;
  localparam logic [6:0]         RETAIN_RESET = 7'h00;
  localparam logic [6:0]         DEC_TEN    = 7'h0A;
  // timing: one tick is a tenth of a second
  localparam real         TENTH_SEC_NS = 100000000.0;
  localparam real         CLK_NS       = 25.0;
  localparam int          TENTH_CYCLES = int'(TENTH_SEC_NS / CLK_NS);
  localparam int          HOUR_TICKS   = 3600;  // tenth-seconds per tenth-hour
  typedef enum logic [1:0] {END_STOP = 2'h0, END_KEEP = 2'h1, END_REPEAT = 2'h2} mrs_end_type;
  typedef enum logic [2:0] {SRC_STORED = 3'h0, SRC_AIN1 = 3'h1, SRC_AIN2 = 3'h2, SRC_AIN3 = 3'h3,
                            SRC_PULSE = 3'h4, SRC_PID = 3'h5, SRC_PRESET = 3'h6} mrs_src_type;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_HOLD = 3'b100} mrs_state_type;
  typedef struct packed {
    logic signed [15:0] analog_input_one;
    logic signed [15:0] analog_input_two;
    logic signed [15:0] analog_input_three;
    logic signed [15:0] pulse_input_terminal;
    logic signed [15:0] pid_output;
    logic signed [15:0] preset_frequency;
  } mrs_sources_type;
  typedef struct packed {
    logic               active;
    logic               reverse;
    logic signed [15:0] percent;
    logic [15:0]        frequency;
    logic [1:0]         ramp_select;
    logic [3:0]         step;
  } mrs_ref_type;
endpackage

// *** hw/mrs_sequencer.sv ***
// Purpose: speed reference selection from sixteen set points, with step sequencer
// Assumes: select terminals are asynchronous pins; reference sources are on clk_sys
// Notes:   Avalon-MM slave, one wait state on every access
//
// Summary of operation
// - set points are signed 0.1 % of maximum frequency, clamped to +-100.0 %, reset 0.
// - negative selected set point drives reverse, positive drives forward.
// - sixteen set points selected by four select terminals.
// - terminal bit3 is index msb, bit0 lsb; all off is 0, all on 15.
// - each step has its own run time and ramp selection.
// - run time 0 to 65535 tenths of the time unit, reset 0.
// - 2-bit ramp selector per step, reset 0.
// - end mode 0 stops after one cycle until next run command.
// - end mode 1 keeps final step frequency and direction.
// - end mode 2 repeats cycles until stop command.
// - retention is decimal; units digit at power down, tens digit at stop.
// - retained state is kept at power down, or at stop unless holding the final step in end mode 1, and resumed later.
// - without retention the sequence restarts from the first step.
// - time unit 0 is seconds, 1 is hours.
// - set point 0 source chosen by 3-bit code 0 to 6.
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mrs_sequencer
  import mrs_pkg::*;
#(
  parameter int TENTH_SEC_CYCLES = TENTH_CYCLES,
  parameter int TICKS_PER_HOUR   = HOUR_TICKS
) (
  input  wire logic                      clk_sys,
  input  wire logic                      reset_n,
  input  wire logic [mrs_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      select_terminal_bit0,
  input  wire logic                      select_terminal_bit1,
  input  wire logic                      select_terminal_bit2,
  input  wire logic                      select_terminal_bit3,
  input  wire logic [15:0]               maximum_frequency,
  input  wire mrs_pkg::mrs_sources_type  sources,
  output mrs_pkg::mrs_ref_type           ref_out
);
  import mrs_pkg::*;

  if (TENTH_SEC_CYCLES < 2 || TENTH_SEC_CYCLES > 2**24) begin : g_chk_tenth
    $error("TENTH_SEC_CYCLES out of range");
  end
  if (TICKS_PER_HOUR < 1 || TICKS_PER_HOUR > 65535) begin : g_chk_hour
    $error("TICKS_PER_HOUR out of range");
  end

  localparam logic [23:0] TENTH_LAST = 24'(TENTH_SEC_CYCLES - 1);
  localparam logic [15:0] HOUR_LAST  = 16'(TICKS_PER_HOUR - 1);
  localparam logic [3:0]  LAST_STEP  = 4'(NUM_STEPS - 1);

  function automatic logic signed [15:0] clamp_sp(input logic [15:0] v);
    logic signed [15:0] s;
    s = signed'(v);
    if (s > SP_MAX) clamp_sp = SP_MAX;
    else if (s < SP_MIN) clamp_sp = SP_MIN;
    else clamp_sp = s;
  endfunction

  function automatic logic [3:0] word_index(input logic [7:0] a);
    word_index = a[5:2];
  endfunction

  // select terminal synchroniser
  logic [3:0] sel_meta_ff;
  logic [3:0] sel_sync_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sel_meta_ff <= 4'h0;
      sel_sync_ff <= 4'h0;
    end else begin
      sel_meta_ff <= {select_terminal_bit3, select_terminal_bit2, select_terminal_bit1, select_terminal_bit0};
      sel_sync_ff <= sel_meta_ff;
    end
  end

  // register file
  logic signed [15:0] sp_ff [NUM_STEPS];
  logic signed [15:0] nxt_sp [NUM_STEPS];
  logic [15:0]        time_ff [NUM_STEPS];
  logic [15:0]        nxt_time [NUM_STEPS];
  logic [1:0]         ramp_ff [NUM_STEPS];
  logic [1:0]         nxt_ramp [NUM_STEPS];
  logic               seq_en_ff;
  logic               nxt_seq_en;
  logic [1:0]         end_mode_ff;
  logic [1:0]         nxt_end_mode;
  logic               unit_hour_ff;
  logic               nxt_unit_hour;
  logic [2:0]         src_ff;
  logic [2:0]         nxt_src;
  logic [6:0]         retain_ff;
  logic [6:0]         nxt_retain;
  logic               ack_ff;
  logic               nxt_ack;
  logic [31:0]        rdata_ff;
  logic [31:0]        nxt_rdata;
  logic               wr_go;
  logic               cmd_run;
  logic               cmd_stop;
  logic               cmd_pdn;
  logic               saved_wr;
  logic               keep_at_pdn;
  logic               keep_at_stop;
  logic [7:0]         addr;

  // sequencer state
  mrs_state_type      state_ff;
  mrs_state_type      nxt_state;
  logic [3:0]         step_ff;
  logic [3:0]         nxt_step;
  logic [15:0]        elapsed_ff;
  logic [15:0]        nxt_elapsed;
  logic [23:0]        pre_ff;
  logic [23:0]        nxt_pre;
  logic [15:0]        hour_ff;
  logic [15:0]        nxt_hour;
  logic               tick;

  assign addr            = avs_address;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata    = rdata_ff;
  assign wr_go           = avs_write & ack_ff;
  assign cmd_run         = wr_go && addr == OFS_COMMAND && avs_writedata[CMD_RUN_BIT];
  assign cmd_stop        = wr_go && addr == OFS_COMMAND && avs_writedata[CMD_STOP_BIT];
  assign cmd_pdn         = wr_go && addr == OFS_COMMAND && avs_writedata[CMD_PDN_BIT];
  assign saved_wr        = wr_go && addr == OFS_SAVED && state_ff == ST_IDLE;
  assign keep_at_pdn     = (retain_ff == 7'h01) || (retain_ff == 7'h0B);
  assign keep_at_stop    = retain_ff >= DEC_TEN;

  always_comb begin
    nxt_ack       = (avs_read | avs_write) & ~ack_ff;
    nxt_rdata     = rdata_ff;
    nxt_seq_en    = seq_en_ff;
    nxt_end_mode  = end_mode_ff;
    nxt_unit_hour = unit_hour_ff;
    nxt_src       = src_ff;
    nxt_retain    = retain_ff;
    for (int i = 0; i < NUM_STEPS; i++) begin
      nxt_sp[i]   = sp_ff[i];
      nxt_time[i] = time_ff[i];
      nxt_ramp[i] = ramp_ff[i];
    end
    if (wr_go) begin
      if (addr < OFS_RUNTIME) begin
        nxt_sp[word_index(addr)] = clamp_sp(avs_writedata[15:0]);
      end else if (addr < OFS_RAMP) begin
        nxt_time[word_index(addr)] = avs_writedata[15:0];
      end else if (addr < OFS_CONFIG) begin
        nxt_ramp[word_index(addr)] = avs_writedata[1:0];
      end else if (addr == OFS_CONFIG) begin
        nxt_seq_en    = avs_writedata[CFG_SEQ_BIT];
        nxt_end_mode  = avs_writedata[CFG_END_LSB +: 2];
        nxt_unit_hour = avs_writedata[CFG_UNIT_BIT];
        nxt_src       = avs_writedata[CFG_SRC_LSB +: 3];
      end else if (addr == OFS_RETAIN) begin
        nxt_retain = avs_writedata[6:0];
      end
    end
    if (avs_read && !ack_ff) begin
      if (addr < OFS_RUNTIME) begin
        nxt_rdata = {{16{sp_ff[word_index(addr)][15]}}, sp_ff[word_index(addr)]};
      end else if (addr < OFS_RAMP) begin
        nxt_rdata = {16'h0000, time_ff[word_index(addr)]};
      end else if (addr < OFS_CONFIG) begin
        nxt_rdata = {30'h00000000, ramp_ff[word_index(addr)]};
      end else if (addr == OFS_CONFIG) begin
        nxt_rdata = {25'h0000000, src_ff, unit_hour_ff, end_mode_ff, seq_en_ff};
      end else if (addr == OFS_RETAIN) begin
        nxt_rdata = {25'h0000000, retain_ff};
      end else if (addr == OFS_STATUS) begin
        nxt_rdata = {21'h000000, state_ff, ref_out.ramp_select, ref_out.reverse, ref_out.active, ref_out.step};
      end else if (addr == OFS_SAVED) begin
        nxt_rdata = {12'h000, elapsed_ff, step_ff};
      end else begin
        nxt_rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff       <= 1'b0;
      rdata_ff     <= 32'h00000000;
      seq_en_ff    <= 1'b0;
      end_mode_ff  <= END_STOP;
      unit_hour_ff <= 1'b0;
      src_ff       <= SRC_STORED;
      retain_ff    <= RETAIN_RESET;
      for (int i = 0; i < NUM_STEPS; i++) begin
        sp_ff[i]   <= SP_RESET;
        time_ff[i] <= TIME_RESET;
        ramp_ff[i] <= RAMP_RESET;
      end
    end else begin
      ack_ff       <= nxt_ack;
      rdata_ff     <= nxt_rdata;
      seq_en_ff    <= nxt_seq_en;
      end_mode_ff  <= nxt_end_mode;
      unit_hour_ff <= nxt_unit_hour;
      src_ff       <= nxt_src;
      retain_ff    <= nxt_retain;
      for (int i = 0; i < NUM_STEPS; i++) begin
        sp_ff[i]   <= nxt_sp[i];
        time_ff[i] <= nxt_time[i];
        ramp_ff[i] <= nxt_ramp[i];
      end
    end
  end

  // step timing and sequence control
  assign tick = (pre_ff == TENTH_LAST) && (!unit_hour_ff || hour_ff == HOUR_LAST);

  always_comb begin
    nxt_state   = state_ff;
    nxt_step    = step_ff;
    nxt_elapsed = elapsed_ff;
    nxt_pre     = (state_ff == ST_RUN && pre_ff != TENTH_LAST) ? pre_ff + 24'h000001 : 24'h000000;
    nxt_hour    = hour_ff;
    if (state_ff == ST_RUN && pre_ff == TENTH_LAST) begin
      nxt_hour = (hour_ff == HOUR_LAST || !unit_hour_ff) ? 16'h0000 : hour_ff + 16'h0001;
    end
    case (state_ff)
      ST_IDLE: begin
        if (cmd_run && seq_en_ff) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (elapsed_ff >= time_ff[step_ff]) begin
          nxt_elapsed = 16'h0000;
          nxt_pre     = 24'h000000;
          nxt_hour    = 16'h0000;
          if (step_ff != LAST_STEP) begin
            nxt_step = step_ff + 4'h1;
          end else begin
            case (end_mode_ff)
              END_KEEP: begin
                nxt_state = ST_HOLD;
              end
              END_REPEAT: begin
                nxt_step = 4'h0;
              end
              default: begin
                nxt_state = ST_IDLE;
                nxt_step  = 4'h0;
              end
            endcase
          end
        end else if (tick) begin
          nxt_elapsed = elapsed_ff + 16'h0001;
        end
      end
      ST_HOLD: begin
        nxt_state = ST_HOLD;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (!seq_en_ff && state_ff != ST_IDLE) begin
      nxt_state = ST_IDLE;
    end
    if (cmd_stop || (!seq_en_ff && state_ff != ST_IDLE)) begin
      nxt_state = ST_IDLE;
      if (!keep_at_stop || state_ff == ST_HOLD) begin
        nxt_step    = 4'h0;
        nxt_elapsed = 16'h0000;
      end else begin
        nxt_step    = step_ff;
        nxt_elapsed = elapsed_ff;
      end
      nxt_pre  = 24'h000000;
      nxt_hour = 16'h0000;
    end
    if (cmd_pdn) begin
      nxt_state = ST_IDLE;
      if (!keep_at_pdn) begin
        nxt_step    = 4'h0;
        nxt_elapsed = 16'h0000;
      end
      nxt_pre  = 24'h000000;
      nxt_hour = 16'h0000;
    end
    if (saved_wr) begin
      nxt_step    = avs_writedata[3:0];
      nxt_elapsed = avs_writedata[19:4];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= ST_IDLE;
      step_ff    <= 4'h0;
      elapsed_ff <= 16'h0000;
      pre_ff     <= 24'h000000;
      hour_ff    <= 16'h0000;
    end else begin
      state_ff   <= nxt_state;
      step_ff    <= nxt_step;
      elapsed_ff <= nxt_elapsed;
      pre_ff     <= nxt_pre;
      hour_ff    <= nxt_hour;
    end
  end

  // reference selection
  logic [3:0]         idx;
  logic signed [15:0] sel_sp;
  logic [15:0]        mag;
  logic [25:0]        prod;
  mrs_ref_type        nxt_ref;
  mrs_ref_type        ref_ff;

  always_comb begin
    idx    = seq_en_ff ? step_ff : sel_sync_ff;
    sel_sp = sp_ff[idx];
    if (idx == 4'h0) begin
      case (mrs_src_type'(src_ff))
        SRC_AIN1:   sel_sp = clamp_sp(sources.analog_input_one);
        SRC_AIN2:   sel_sp = clamp_sp(sources.analog_input_two);
        SRC_AIN3:   sel_sp = clamp_sp(sources.analog_input_three);
        SRC_PULSE:  sel_sp = clamp_sp(sources.pulse_input_terminal);
        SRC_PID:    sel_sp = clamp_sp(sources.pid_output);
        SRC_PRESET: sel_sp = clamp_sp(sources.preset_frequency);
        default:    sel_sp = sp_ff[0];
      endcase
    end
    if (seq_en_ff && state_ff == ST_IDLE) begin
      sel_sp = SP_RESET;
    end
    mag  = sel_sp[15] ? 16'(-sel_sp) : 16'(sel_sp);
    prod = 26'(mag[9:0]) * 26'(maximum_frequency);
    nxt_ref.active      = !seq_en_ff || state_ff != ST_IDLE;
    nxt_ref.reverse     = sel_sp[15];
    nxt_ref.percent     = sel_sp;
    nxt_ref.frequency   = 16'(prod / PCT_FULL);
    nxt_ref.ramp_select = seq_en_ff ? ramp_ff[step_ff] : RAMP_RESET;
    nxt_ref.step        = idx;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ref_ff <= '0;
    end else begin
      ref_ff <= nxt_ref;
    end
  end
  assign ref_out = ref_ff;

  // checks
  AST_CLAMP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ref_out.percent <= SP_MAX && ref_out.percent >= SP_MIN) else $error("set point outside range");
  AST_DIR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ref_out.reverse == (ref_out.percent < 0)) else $error("direction does not follow sign");
  AST_SELECT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !seq_en_ff && $stable(sel_sync_ff) && $stable(seq_en_ff) |=> ref_out.step == $past(sel_sync_ff))
    else $error("terminal index not applied");
  AST_ADVANCE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_ff == ST_RUN && elapsed_ff >= time_ff[step_ff] && step_ff != LAST_STEP && !cmd_stop && !cmd_pdn
    && seq_en_ff && !saved_wr |=> step_ff == $past(step_ff) + 4'h1) else $error("step did not advance");
  AST_END_STOP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_ff == ST_RUN && step_ff == LAST_STEP && elapsed_ff >= time_ff[step_ff] && end_mode_ff == END_STOP
    && !cmd_stop && !cmd_pdn |=> state_ff == ST_IDLE && step_ff == 4'h0) else $error("cycle end did not stop");
  AST_END_KEEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_ff == ST_HOLD && !cmd_stop && !cmd_pdn && seq_en_ff |=> state_ff == ST_HOLD && $stable(step_ff))
    else $error("final step not kept");
  AST_REPEAT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_ff == ST_RUN && step_ff == LAST_STEP && elapsed_ff >= time_ff[step_ff] && end_mode_ff == END_REPEAT
    && !cmd_stop && !cmd_pdn && seq_en_ff && !saved_wr |=> state_ff == ST_RUN && step_ff == 4'h0)
    else $error("cycle did not repeat");
  AST_NO_RETAIN: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cmd_pdn && !keep_at_pdn |=> step_ff == 4'h0 && elapsed_ff == 16'h0000) else $error("state kept at power down");
  AST_RETAIN_STOP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cmd_stop && keep_at_stop && state_ff == ST_RUN && !saved_wr |=> state_ff == ST_IDLE && $stable(step_ff))
    else $error("state lost at stop");
  AST_HOLD_TIME: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_ff == ST_RUN && elapsed_ff < time_ff[step_ff] && !tick && seq_en_ff && !cmd_stop && !cmd_pdn
    && !saved_wr |=> $stable(step_ff) && $stable(elapsed_ff)) else $error("step left early");
  COV_ADVANCE: cover property (@(posedge clk_sys) disable iff (!reset_n)
    state_ff == ST_RUN ##1 step_ff != $past(step_ff));
  COV_HOLD: cover property (@(posedge clk_sys) disable iff (!reset_n) state_ff == ST_HOLD);
  COV_REVERSE: cover property (@(posedge clk_sys) disable iff (!reset_n) ref_out.reverse && ref_out.active);
endmodule // mrs_sequencer
`default_nettype wire

// *** test/mrs_switch_model.sv ***
// Purpose: selector switches that drive the four set point select terminals
// Assumes: the bench names the wanted index
// Notes:   all four contacts move together
`timescale 1ns/1ps
`default_nettype none
module mrs_switch_model (
  input  wire logic [3:0] want_index,
  output logic            sw_bit0,
  output logic            sw_bit1,
  output logic            sw_bit2,
  output logic            sw_bit3
);
  // whole combination held until the next index is wanted
  assign {sw_bit3, sw_bit2, sw_bit1, sw_bit0} = want_index;
endmodule  // mrs_switch_model
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: self-checking bench of the set point selector and step sequencer
// Assumes: tenth-second prescale cut to 4 clocks, 3 ticks per tenth-hour
// Notes:   every wait is bounded
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mrs_pkg::*;
  localparam int T = 4;
  localparam int H = 3;
  logic              clk_sys;
  logic              reset_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [3:0]        want_index;
  logic [3:0]        sw;
  mrs_sources_type   sources;
  mrs_ref_type       ref_out;
  logic [31:0]       q;
  int                n_fail;
  int                compares;
  int                sp [16];
  mrs_switch_model i_mrs_switch_model (.want_index(want_index), .sw_bit0(sw[0]), .sw_bit1(sw[1]),
    .sw_bit2(sw[2]), .sw_bit3(sw[3]));
  mrs_sequencer #(.TENTH_SEC_CYCLES(T), .TICKS_PER_HOUR(H)) i_mrs_sequencer (.clk_sys(clk_sys),
    .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .select_terminal_bit0(sw[0]), .select_terminal_bit1(sw[1]), .select_terminal_bit2(sw[2]),
    .select_terminal_bit3(sw[3]), .maximum_frequency(16'h1388), .sources(sources), .ref_out(ref_out));
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic overrun();
    n_fail++;
    $display("unexpected at %0t: got %h expected %h", $time, 32'h1, 32'h0);
    finish_test();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic w;
    int   n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      w = avs_waitrequest;
      n++;
    end while (w !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) overrun();
  endtask
  task automatic wait_step(input logic [3:0] s);
    int n;
    n = 0;
    while (ref_out.step !== s && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 3000) overrun();
  endtask
  task automatic set_times(input logic [31:0] t0, input logic [31:0] t);
    for (int i = 0; i < 16; i++) bus(1'b1, 8'(8'h40 + 4 * i), (i == 0) ? t0 : t);
  endtask
  task automatic t_defaults();
    logic [7:0] a [6];
    a = '{8'h3C, 8'h7C, 8'hBC, OFS_CONFIG, OFS_RETAIN, OFS_TOP};
    foreach (a[i]) begin
      bus(1'b0, a[i], 32'h0);
      chk(q, 32'h0);
    end
    bus(1'b1, 8'h7C, 32'h0001FFFF);
    bus(1'b0, 8'h7C, 32'h0);
    chk(q, 32'h0000FFFF);
  endtask
  task automatic t_multiref();
    int e;
    for (int i = 0; i < 16; i++) begin
      e = i * 137 - 1000;
      sp[i] = (e > 1000) ? 1000 : e;
      bus(1'b1, 8'(4 * i), 32'(e));
    end
    bus(1'b0, 8'h04, 32'h0);
    chk(q, 32'(sp[1]));
    for (int i = 15; i >= 0; i--) begin
      want_index <= 4'(i);
      cyc(5);
      chk({ref_out.active, ref_out.reverse, ref_out.step, ref_out.percent},
          {1'b1, 1'(sp[i] < 0), 4'(i), 16'(sp[i])});
      chk(ref_out.frequency, 32'((sp[i] < 0 ? -sp[i] : sp[i]) * 5));
    end
  endtask
  task automatic t_sources();
    logic [15:0] ex [8];
    ex = '{16'hFC18, 16'h006F, 16'hFF22, 16'h014D, 16'h01BC, 16'hFDD5, 16'h03E8, 16'hFC18};
    sources <= {16'h006F, 16'hFF22, 16'h014D, 16'h01BC, 16'hFDD5, 16'h04B0};
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, OFS_CONFIG, 32'(c << 4));
      cyc(3);
      chk({16'h0, ref_out.percent}, {16'h0, ex[c]});
    end
  endtask
  task automatic t_cycle(input logic [1:0] m);
    logic [3:0] cur;
    logic [3:0] nx;
    int         n;
    int         k;
    set_times(32'h1, 32'h1);
    for (int i = 0; i < 16; i++) bus(1'b1, 8'(8'h80 + 4 * i), 32'(i % 4));
    bus(1'b1, OFS_CONFIG, {29'h0, m, 1'b1});
    bus(1'b1, OFS_COMMAND, 32'h1);
    cur = 4'h0;
    k = 0;
    n = 0;
    while (k < (m == 2'h1 ? 15 : 16) && n < 4000) begin
      @(negedge clk_sys);
      n++;
      if (ref_out.step !== cur) begin
        nx = cur + 4'h1;
        chk(ref_out.step, nx);
        if (ref_out.active === 1'b1) chk({ref_out.ramp_select, ref_out.percent}, {nx[1:0], 16'(sp[nx])});
        else chk({m == 2'h2, nx}, 5'h0);
        cur = nx;
        k++;
      end
    end
    if (n >= 4000) overrun();
    cyc(40);
    bus(1'b0, OFS_STATUS, 32'h0);
    if (m == 2'h1) chk({q[10:8], q[4:0], ref_out.percent}, {8'h9F, 16'h03E8});
    else chk({q[10:8], q[4]}, (m == 2'h2) ? 4'h5 : 4'h2);
    bus(1'b1, OFS_COMMAND, 32'h2);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({q[10:8], q[4]}, 4'h2);
  endtask
  task automatic t_retain();
    logic [31:0] sv;
    set_times(32'h3, 32'h3);
    bus(1'b1, OFS_CONFIG, 32'h1);
    bus(1'b1, OFS_RETAIN, 32'hA);
    bus(1'b1, OFS_COMMAND, 32'h1);
    wait_step(4'h3);
    bus(1'b1, OFS_COMMAND, 32'h2);
    bus(1'b0, OFS_SAVED, 32'h0);
    chk(q[3:0], 4'h3);
    bus(1'b1, OFS_COMMAND, 32'h1);
    cyc(2);
    chk({ref_out.active, ref_out.step}, 5'h13);
    bus(1'b1, OFS_RETAIN, 32'h1);
    bus(1'b1, OFS_COMMAND, 32'h2);
    bus(1'b0, OFS_SAVED, 32'h0);
    chk(q[3:0], 4'h0);
    bus(1'b1, OFS_COMMAND, 32'h1);
    wait_step(4'h2);
    bus(1'b1, OFS_COMMAND, 32'h4);
    bus(1'b0, OFS_SAVED, 32'h0);
    chk(q[3:0], 4'h2);
    sv = q;
    bus(1'b1, OFS_RETAIN, 32'h0);
    bus(1'b1, OFS_COMMAND, 32'h1);
    bus(1'b1, OFS_COMMAND, 32'h4);
    bus(1'b0, OFS_SAVED, 32'h0);
    chk(q[3:0], 4'h0);
    reset_n <= 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    bus(1'b0, OFS_SAVED, 32'h0);
    chk(q, 32'h0);
    set_times(32'h3, 32'h3);
    bus(1'b1, OFS_CONFIG, 32'h1);
    bus(1'b1, OFS_SAVED, sv);
    bus(1'b1, OFS_COMMAND, 32'h1);
    cyc(2);
    chk({ref_out.active, ref_out.step}, 5'h12);
  endtask
  task automatic t_unit(input logic u);
    int n;
    int m;
    m = u ? H : 1;
    set_times(32'h2, 32'h0);
    bus(1'b1, OFS_CONFIG, {28'h0, u, 3'h1});
    bus(1'b1, OFS_COMMAND, 32'h1);
    n = 0;
    while (ref_out.step === 4'h0 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    chk(32'(n >= T * m && n <= 2 * T * m + 3), 32'h1);
    cyc(40);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    reset_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    want_index = 4'h0;
    sources = '0;
    n_fail = 0;
    compares = 0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_defaults();
    t_multiref();
    t_sources();
    t_cycle(2'h0);
    t_cycle(2'h1);
    t_cycle(2'h2);
    t_cycle(2'h3);
    t_retain();
    t_unit(1'b0);
    t_unit(1'b1);
    finish_test();
  end
endmodule  // testbench
`default_nettype wire
